// [logic/pmf_fabric.sv]
// Programmable macrocell fabric: routing matrix, term arrays, allocators, macrocells, pins
`timescale 1ns/1ns

module pmf_fabric #(
    parameter logic [pmf_pkg::NBLK*pmf_pkg::NIN*pmf_pkg::SRC_W-1:0]            ROUTE_SEL = '0,
    parameter logic [pmf_pkg::NBLK*pmf_pkg::NPT*pmf_pkg::NLIT-1:0]             AND_MASK  = '0,
    parameter logic [pmf_pkg::NMCALL*pmf_pkg::MAXPT*pmf_pkg::PT_W-1:0]         PT_SEL    = '0,
    parameter logic [pmf_pkg::NMCALL*pmf_pkg::CNT_W-1:0]                       PT_CNT    = '0,
    parameter logic [pmf_pkg::NMCALL*2-1:0]                                    STORE     = '0,
    parameter logic [pmf_pkg::NMCALL-1:0]                                      INVERT    = '0,
    parameter logic [pmf_pkg::NMCALL-1:0]                                      CLK_SEL   = '0,
    parameter logic [pmf_pkg::NMCALL*2-1:0]                                    INREG     = '0,
    parameter logic [pmf_pkg::NIO-1:0]                                         OUT_EN    = '0
) (
    input  wire logic                 clock,
    input  wire logic                 nrst,
    input  wire pmf_pkg::pmf_io_in_t  ioPad,
    input  wire pmf_pkg::pmf_ded_in_t dedPad,
    output pmf_pkg::pmf_io_out_t      ioDrive,
    output logic [pmf_pkg::NIO-1:0]   ioLevel,
    output logic [pmf_pkg::NDED-1:0]  dedLevel,
    output logic [pmf_pkg::NMCALL-1:0] mcOut
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [pmf_pkg::NIO-1:0]          ioHold;
    logic [pmf_pkg::NIO-1:0]          next_ioHold;
    logic [pmf_pkg::NDED-1:0]         dedHold;
    logic [pmf_pkg::NDED-1:0]         next_dedHold;
    logic [pmf_pkg::NGCLK-1:0]        gclkLvl;
    logic [pmf_pkg::NGCLK-1:0]        gclkPrev;
    logic [pmf_pkg::NGCLK-1:0]        gclkRise;
    logic [(2**pmf_pkg::SRC_W)-1:0]   src;
    logic [pmf_pkg::NIN-1:0]          blkIn  [pmf_pkg::NBLK];
    logic [pmf_pkg::NPT-1:0]          blkPt  [pmf_pkg::NBLK];
    logic [pmf_pkg::NMCALL-1:0]       sumOut;

    // OR of the first cnt selected terms; a term may be picked by many sums
    function automatic logic sum_terms(
        input logic [pmf_pkg::NPT-1:0]                 pts,
        input logic [pmf_pkg::MAXPT*pmf_pkg::PT_W-1:0] sel,
        input logic [pmf_pkg::CNT_W-1:0]               cnt
    );
        logic                    acc;
        logic [pmf_pkg::PT_W-1:0] idx;
        acc = 1'b0;
        idx = '0;
        for (int k = 0; k < pmf_pkg::MAXPT; k++) begin
            idx = sel[k*pmf_pkg::PT_W +: pmf_pkg::PT_W];
            if ((k < int'(cnt)) && (int'(idx) < pmf_pkg::NPT)) begin
                acc = acc | pts[idx];
            end
        end
        return acc;
    endfunction : sum_terms

    // ****************************************************************
    // Pins with bus hold
    // ****************************************************************
    // Undriven pins keep the last level; a pin the fabric drives is seen one edge later
    assign next_ioHold = (~ioDrive.oe_n & ioDrive.level)
                       | (ioDrive.oe_n & ioPad.driven & ioPad.level)
                       | (ioDrive.oe_n & ~ioPad.driven & ioHold);
    assign ioLevel     = (ioPad.driven & ioPad.level) | (~ioPad.driven & ioHold);
    assign next_dedHold = (dedPad.driven & dedPad.level) | (~dedPad.driven & dedHold);
    assign dedLevel     = next_dedHold;

    // Hold latches
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ioHold  <= '0;
            dedHold <= '0;
        end else begin
            ioHold  <= next_ioHold;
            dedHold <= next_dedHold;
        end
    end

    // ****************************************************************
    // Global clocks from the clock-capable inputs
    // ****************************************************************
    assign gclkLvl  = dedLevel[pmf_pkg::GCLK_BASE +: pmf_pkg::NGCLK];
    assign gclkRise = gclkLvl & ~gclkPrev;

    // Edge detection of the global clocks
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            gclkPrev <= '0;
        end else begin
            gclkPrev <= gclkLvl;
        end
    end

    // ****************************************************************
    // Global routing matrix and product-term arrays
    // ****************************************************************
    // One flat source list, every entry reached through the same mux
    assign src = {{pmf_pkg::SRC_PAD{1'b0}}, mcOut, dedLevel, ioLevel};

    for (genvar b = 0; b < pmf_pkg::NBLK; b++) begin : g_blk
        logic [pmf_pkg::NLIT-1:0] lits;

        // Block inputs picked from the routing matrix
        for (genvar j = 0; j < pmf_pkg::NIN; j++) begin : g_in
            wire logic [pmf_pkg::SRC_W-1:0] sel =
                ROUTE_SEL[(b*pmf_pkg::NIN+j)*pmf_pkg::SRC_W +: pmf_pkg::SRC_W];
            assign blkIn[b][j] = src[sel];
        end

        // True and complement literals
        assign lits = {~blkIn[b], blkIn[b]};

        // AND of the literals whose mask bit is set
        for (genvar t = 0; t < pmf_pkg::NPT; t++) begin : g_pt
            wire logic [pmf_pkg::NLIT-1:0] mask =
                AND_MASK[(b*pmf_pkg::NPT+t)*pmf_pkg::NLIT +: pmf_pkg::NLIT];
            assign blkPt[b][t] = &(lits | ~mask);
        end
    end

    // ****************************************************************
    // Macrocells
    // ****************************************************************
    for (genvar m = 0; m < pmf_pkg::NMCALL; m++) begin : g_mc
        localparam int  BLK    = m / pmf_pkg::NMC;
        localparam int  PIN    = m / 2;
        localparam bit  BURIED = (m % 2) == 1;
        localparam logic [1:0] IR = BURIED ? INREG[m*2 +: 2] : pmf_pkg::INREG_NONE;
        localparam logic [1:0] MD =
            (IR == pmf_pkg::INREG_DFF)   ? pmf_pkg::STORE_DFF :
            (IR == pmf_pkg::INREG_LATCH) ? pmf_pkg::STORE_LATCH :
                                           STORE[m*2 +: 2];
        logic q;
        wire logic d;
        wire logic rise;
        wire logic open;
        wire logic core;

        // Sum of allocated terms of the own block
        assign sumOut[m] = sum_terms(blkPt[BLK],
            PT_SEL[m*pmf_pkg::MAXPT*pmf_pkg::PT_W +: pmf_pkg::MAXPT*pmf_pkg::PT_W],
            PT_CNT[m*pmf_pkg::CNT_W +: pmf_pkg::CNT_W]);
        // Input register takes the neighbour pin instead of the sum
        assign d    = (IR != pmf_pkg::INREG_NONE) ? ioLevel[PIN] : sumOut[m];
        assign rise = gclkRise[CLK_SEL[m]];
        assign open = gclkLvl[CLK_SEL[m]];

        // Storage element
        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                q <= 1'b0;
            end else if ((MD == pmf_pkg::STORE_DFF) && rise) begin
                q <= d;
            end else if ((MD == pmf_pkg::STORE_TFF) && rise) begin
                q <= q ^ d;
            end else if ((MD == pmf_pkg::STORE_LATCH) && open) begin
                q <= d;
            end
        end

        // Bypass or transparent latch pass d, then polarity
        assign core = ((MD == pmf_pkg::STORE_COMB) ||
                       ((MD == pmf_pkg::STORE_LATCH) && open)) ? d : q;
        assign mcOut[m] = core ^ INVERT[m];
    end

    // ****************************************************************
    // Pin drivers from the I/O macrocells
    // ****************************************************************
    for (genvar p = 0; p < pmf_pkg::NIO; p++) begin : g_pin
        assign ioDrive.level[p] = mcOut[2*p];
        assign ioDrive.oe_n[p]  = ~OUT_EN[p];
    end

endmodule : pmf_fabric

// [logic/pmf_pkg.sv]
// Shared sizes, source map, mode codes and pin bundles of the macrocell fabric
package pmf_pkg;

    // ****************************************************************
    // Fabric sizes
    // ****************************************************************
    localparam int NBLK      = 4;       // Logic blocks
    localparam int NMC       = 16;      // Macrocells per block
    localparam int NIN       = 36;      // Routing matrix signals per block
    localparam int NLIT      = 2 * NIN; // True and complement literals
    localparam int NPT       = 86;      // Product terms per block
    localparam int MAXPT     = 16;      // Most terms on one sum
    localparam int NMCALL    = NBLK * NMC;
    localparam int NIO       = NMCALL / 2; // One pin per macrocell pair
    localparam int NIOBLK    = NMC / 2;
    localparam int NDED      = 5;       // Dedicated inputs
    localparam int NGCLK     = 2;       // Global clocks
    localparam int GCLK_BASE = 3;       // First clock-capable dedicated input

    // ****************************************************************
    // Field widths and routing source map
    // ****************************************************************
    localparam int SRC_W   = 7;
    localparam int PT_W    = 7;
    localparam int CNT_W   = 5;
    localparam int SRC_IO  = 0;
    localparam int SRC_DED = SRC_IO + NIO;
    localparam int SRC_MC  = SRC_DED + NDED;
    localparam int NSRC    = SRC_MC + NMCALL;
    localparam int SRC_PAD = (2 ** SRC_W) - NSRC;

    // ****************************************************************
    // Storage and input-register mode codes
    // ****************************************************************
    localparam logic [1:0] STORE_COMB  = 2'h0;
    localparam logic [1:0] STORE_DFF   = 2'h1;
    localparam logic [1:0] STORE_TFF   = 2'h2;
    localparam logic [1:0] STORE_LATCH = 2'h3;
    localparam logic [1:0] INREG_NONE  = 2'h0;
    localparam logic [1:0] INREG_DFF   = 2'h1;
    localparam logic [1:0] INREG_LATCH = 2'h2;

    // ****************************************************************
    // Pin bundles
    // ****************************************************************
    typedef struct packed {
        logic [NIO-1:0] level;  // Level an outside driver puts on the pin
        logic [NIO-1:0] driven; // Outside driver active
    } pmf_io_in_t;

    typedef struct packed {
        logic [NDED-1:0] level;
        logic [NDED-1:0] driven;
    } pmf_ded_in_t;

    typedef struct packed {
        logic [NIO-1:0] level;  // Level the fabric drives
        logic [NIO-1:0] oe_n;   // Low while the fabric drives the pin
    } pmf_io_out_t;

endpackage : pmf_pkg

// [test/pmf_fabric_chk.sv]
// Port checker for the macrocell fabric under the bench configuration
`timescale 1ns/1ns
module pmf_fabric_chk (
    input wire logic                       clock,
    input wire logic                       nrst,
    input wire pmf_pkg::pmf_io_in_t        ioPad,
    input wire pmf_pkg::pmf_ded_in_t       dedPad,
    input wire pmf_pkg::pmf_io_out_t       ioDrive,
    input wire logic [pmf_pkg::NIO-1:0]    ioLevel,
    input wire logic [pmf_pkg::NDED-1:0]   dedLevel,
    input wire logic [pmf_pkg::NMCALL-1:0] mcOut
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    logic [pmf_pkg::NIO-1:0] evenOut;
    logic [1:0]              clkPrev;
    logic [1:0]              clkRise;
    // Even macrocells face the pins
    always_comb begin
        for (int p = 0; p < pmf_pkg::NIO; p++) begin
            evenOut[p] = mcOut[2*p];
        end
    end
    assign clkRise = dedLevel[4:3] & ~clkPrev;
    // Clock pin levels at the last edge
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            clkPrev <= 2'h0;
        end else begin
            clkPrev <= dedLevel[4:3];
        end
    end
    sequence s_rise0; !dedLevel[3] ##1 dedLevel[3]; endsequence
    sequence s_rise1; !dedLevel[4] ##1 dedLevel[4]; endsequence
    a_pin_follows: assert property (((ioLevel ^ ioPad.level) & ioPad.driven) == '0)
        else $error("pin level differs from driver");
    a_pin_hold: assert property (nrst && $past(nrst) |->
        ((ioLevel ^ $past(ioLevel)) & ~ioPad.driven & ioDrive.oe_n) == '0) else $error("pin lost");
    a_ded_hold: assert property (nrst && $past(nrst) |->
        ((dedLevel ^ $past(dedLevel)) & ~dedPad.driven) == '0) else $error("input lost");
    a_oe_static: assert property ($stable(ioDrive.oe_n)) else $error("enable moved");
    a_pin_pairs: assert property (ioDrive.level == evenOut) else $error("pin pairing");
    a_comb_sum: assert property (mcOut[0] == ioLevel[0] && mcOut[10] && mcOut[2] != mcOut[0]
        && mcOut[12] == mcOut[2]) else $error("comb sum wrong");
    a_block_link: assert property (mcOut[16] == mcOut[0] && mcOut[14] == mcOut[4])
        else $error("routing feedback wrong");
    a_dff_load: assert property (s_rise0 |=>
        mcOut[4] == ($past(ioLevel[0]) | $past(ioLevel[1]))
        && mcOut[1] == $past(ioLevel[0])) else $error("register load wrong");
    a_dff_hold: assert property (!clkRise[0] |=> $stable(mcOut[4]) && $stable(mcOut[1]))
        else $error("register moved");
    a_tff_step: assert property (s_rise1 |=>
        mcOut[6] == ($past(mcOut[6]) ^ $past(ioLevel[1])))
        else $error("toggle wrong");
    a_latch_open: assert property (dedLevel[3] |->
        mcOut[8] == ioLevel[0] && mcOut[3] == ioLevel[1])
        else $error("latch not open");
endmodule : pmf_fabric_chk
bind pmf_fabric pmf_fabric_chk chk (.clock(clock), .nrst(nrst), .ioPad(ioPad), .dedPad(dedPad),
    .ioDrive(ioDrive), .ioLevel(ioLevel), .dedLevel(dedLevel), .mcOut(mcOut));

// [test/tb_top.sv]
// Self-checking bench for the macrocell fabric
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_top;
    localparam logic [1007:0] RSEL = 1008'(7'h01) << 7 | 1008'(7'h29) << 14 | 1008'(7'h25) << 252;
    localparam logic [24767:0] AMASK = 24768'(1'h1) | 24768'(1'h1) << 108 | 24768'(1'h1) << 145
        | 24768'(1'h1) << 218 | 24768'(1'h1) << 6192;
    localparam logic [7167:0] PSEL = 7168'(7'h02) << 455 | 7168'(7'h02) << 672
        | 7168'(7'h03) << 1568 | 7168'(7'h01) << 1344;
    localparam logic [319:0] CNT = 320'(5'h01) | 320'(5'h01) << 10 | 320'(5'h02) << 20
        | 320'(5'h01) << 30 | 320'(5'h01) << 40 | 320'(5'h01) << 60 | 320'(5'h01) << 70
        | 320'(5'h01) << 80;
    logic                 clock;
    logic                 nrst;
    pmf_pkg::pmf_io_in_t  ioPad;
    pmf_pkg::pmf_ded_in_t dedPad;
    pmf_pkg::pmf_io_out_t ioDrive;
    logic [31:0]          ioLevel;
    logic [4:0]           dedLevel;
    logic [63:0]          mcOut;
    int                   miscompares = 0;
    int                   n_checks = 0;
    pmf_fabric #(.ROUTE_SEL(RSEL), .AND_MASK(AMASK), .PT_SEL(PSEL), .PT_CNT(CNT),
        .STORE(128'h3_2100), .INVERT(64'h404), .CLK_SEL(64'h40), .INREG(128'h84),
        .OUT_EN(32'h4)) uut (.clock(clock), .nrst(nrst), .ioPad(ioPad), .dedPad(dedPad),
        .ioDrive(ioDrive), .ioLevel(ioLevel), .dedLevel(dedLevel), .mcOut(mcOut));
    always #5 clock = ~clock;
    task automatic pins(input logic [1:0] v);
        @(negedge clock) ioPad.level[1:0] = v;
        #1;
    endtask : pins
    // One low-high-low period on a global clock pin
    task automatic gclk(input int c);
        @(negedge clock) dedPad.level[3+c] = 1'h1;
        @(negedge clock) dedPad.level[3+c] = 1'h0;
        #1;
    endtask : gclk
    task automatic finish_test();
        if (miscompares == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        #20000;
        miscompares++;
        finish_test();
    end
    initial begin
        clock = 1'h0;
        nrst = 1'h0;
        ioPad = '{level: 32'h0, driven: 32'h3};
        dedPad = '{level: 5'h0, driven: 5'h1F};
        repeat (16) @(negedge clock);
        nrst = 1'h1;
        for (int v = 0; v < 4; v++) begin
            pins(v[1:0]);
            `CHK("comb", {~v[0], 1'h1, ~v[0], v[0], v[0]},
                {mcOut[12], mcOut[10], mcOut[2], mcOut[0], mcOut[16]})
        end
        pins(2'h1);
        gclk(0);
        `CHK("dff", 4'hF, {mcOut[4], mcOut[1], mcOut[14], ioDrive.level[2]})
        pins(2'h2);
        `CHK("dffhold", 2'h3, {mcOut[4], mcOut[1]})
        gclk(0);
        `CHK("inreg", 2'h2, {mcOut[4], mcOut[1]})
        for (int k = 0; k < 2; k++) begin
            gclk(1);
            `CHK("tff", ~k[0], mcOut[6])
        end
        @(negedge clock) dedPad.level[3] = 1'h1;
        pins(2'h1);
        `CHK("latch", 2'h2, {mcOut[8], mcOut[3]})
        @(negedge clock) dedPad.level[3] = 1'h0;
        pins(2'h2);
        `CHK("latchhold", 2'h2, {mcOut[8], mcOut[3]})
        @(negedge clock) dedPad.level[0] = 1'h1;
        @(negedge clock) ioPad = '{level: 32'h0, driven: 32'h0};
        dedPad = '{level: 5'h0, driven: 5'h0};
        @(negedge clock) `CHK("hold", 3'h5, {ioLevel[1:0], dedLevel[0]})
        `CHK("oe", 32'hFFFF_FFFB, ioDrive.oe_n)
        nrst = 1'h0;
        #1 `CHK("reset", 4'h0, {mcOut[6], mcOut[4], ioLevel[1:0]})
        @(negedge clock) nrst = 1'h1;
        repeat (3) @(negedge clock);
        finish_test();
    end
endmodule : tb_top
